// *** fapes_defines.vh ***
// Constants for the flash program and erase host sequencer
`ifndef FAPES_DEFINES_VH
`define FAPES_DEFINES_VH

// Clock rate
`define FAPES_CLK_MHZ          10
`define FAPES_CLK_HZ           10000000

// Operation codes on the user command port
`define FAPES_OP_NONE          2'h0
`define FAPES_OP_PROGRAM       2'h1
`define FAPES_OP_CHIP_ERASE    2'h2
`define FAPES_OP_SECTOR_ERASE  2'h3

// Times in their own units
`define FAPES_PROG_MAX_US      210
`define FAPES_SECTOR_LOAD_US   80
`define FAPES_SECTOR_ERASE_S   8
`define FAPES_CHIP_ERASE_S     24

// Cycle counts of the times above at the 10 MHz clock, sized to their counters
`define FAPES_PROG_CYC         28'h0000834
`define FAPES_LOAD_CYC         10'h320
`define FAPES_SECTOR_CYC       28'h4C4B400
`define FAPES_CHIP_CYC         28'hE4E1C00

// Read access wait, covers access time and the input synchroniser
`define FAPES_READ_WAIT        3'h4

// Status bit positions
`define FAPES_POLL_BIT         7
`define FAPES_TOGGLE_BIT       6

// Sector select lines
`define FAPES_SEC_LOW_LINE     13
`define FAPES_SEC_HIGH_LINE    16

// Command sequence lengths, index of the last write
`define FAPES_PROG_LAST        3'h3
`define FAPES_ERASE_LAST       3'h5

// Default command sequence words
`define FAPES_UNLOCK_ADDR1     17'h00555
`define FAPES_UNLOCK_ADDR2     17'h002AA
`define FAPES_UNLOCK_DATA1     8'hAA
`define FAPES_UNLOCK_DATA2     8'h55
`define FAPES_PROG_SETUP       8'hA0
`define FAPES_ERASE_SETUP      8'h80
`define FAPES_CHIP_CONFIRM     8'h10
`define FAPES_SECTOR_CONFIRM   8'h30

`endif

// *** fapes_host.v ***
// Host sequencer that programs and erases a parallel flash and polls its status
`timescale 1ns/100ps
`include "fapes_defines.vh"

module fapes_host #(
    parameter [27:0] SECTOR_ERASE_CYCLES = `FAPES_SECTOR_CYC,
    parameter [27:0] CHIP_ERASE_CYCLES   = `FAPES_CHIP_CYC,
    parameter [16:0] UNLOCK_ADDR1        = `FAPES_UNLOCK_ADDR1,
    parameter [16:0] UNLOCK_ADDR2        = `FAPES_UNLOCK_ADDR2
) (
    input  wire        clock,
    input  wire        rst,
    input  wire        cmd_valid,
    input  wire [1:0]  cmd_op,
    input  wire [16:0] cmd_addr,
    input  wire [3:0]  cmd_sector,
    input  wire [7:0]  cmd_data,
    output reg         cmd_ready,
    output reg         op_done,
    output reg         op_fail,
    output reg  [7:0]  status_byte,
    output reg  [16:0] flash_addr,
    output reg  [7:0]  flash_dq_out,
    output reg         flash_dq_oe,
    input  wire [7:0]  flash_dq_in,
    output reg         flash_ce_n,
    output reg         flash_oe_n,
    output reg         flash_we_n
);

////////////////////////////////////////////////////////////////////////////////
// States

localparam [8:0] S_IDLE  = 9'h001;
localparam [8:0] S_WSET  = 9'h002;
localparam [8:0] S_WLOW  = 9'h004;
localparam [8:0] S_WHIGH = 9'h008;
localparam [8:0] S_WEND  = 9'h010;
localparam [8:0] S_LOAD  = 9'h020;
localparam [8:0] S_RSET  = 9'h040;
localparam [8:0] S_RWAIT = 9'h080;
localparam [8:0] S_CHECK = 9'h100;

localparam [27:0] PROG_CYCLES = `FAPES_PROG_CYC;
localparam [9:0]  LOAD_CYCLES = `FAPES_LOAD_CYC;

reg [8:0]  state;
reg [1:0]  op;
reg [2:0]  step;
reg [16:0] tgt_addr;
reg [7:0]  tgt_data;
reg [3:0]  tgt_sector;
reg [9:0]  wait_cnt;
reg [27:0] tmo_cnt;
reg [27:0] tmo_limit;
reg [7:0]  cur_dq;
reg [7:0]  prev_dq;
reg        have_prev;
reg [7:0]  dq_meta;
reg [7:0]  dq_sync;

wire [2:0] last_step = (op == `FAPES_OP_PROGRAM) ? `FAPES_PROG_LAST : `FAPES_ERASE_LAST;
wire       expect7   = (op == `FAPES_OP_PROGRAM) ? tgt_data[`FAPES_POLL_BIT] : 1'b1;
wire [16:0] sector_addr = {tgt_sector, {`FAPES_SEC_LOW_LINE{1'b0}}};

////////////////////////////////////////////////////////////////////////////////
// Command sequence tables

function [16:0] seq_addr;
    input [1:0]  f_op;
    input [2:0]  f_step;
    input [16:0] f_tgt;
    input [16:0] f_sec;
    begin
        case (f_step)
            3'h0: seq_addr = UNLOCK_ADDR1;
            3'h1: seq_addr = UNLOCK_ADDR2;
            3'h2: seq_addr = UNLOCK_ADDR1;
            3'h3: seq_addr = (f_op == `FAPES_OP_PROGRAM) ? f_tgt : UNLOCK_ADDR1;
            3'h4: seq_addr = UNLOCK_ADDR2;
            3'h5: seq_addr = (f_op == `FAPES_OP_SECTOR_ERASE) ? f_sec : UNLOCK_ADDR1;
            default: seq_addr = UNLOCK_ADDR1;
        endcase
    end
endfunction

function [7:0] seq_data;
    input [1:0] f_op;
    input [2:0] f_step;
    input [7:0] f_data;
    begin
        case (f_step)
            3'h0: seq_data = `FAPES_UNLOCK_DATA1;
            3'h1: seq_data = `FAPES_UNLOCK_DATA2;
            3'h2: seq_data = (f_op == `FAPES_OP_PROGRAM) ? `FAPES_PROG_SETUP
                                                         : `FAPES_ERASE_SETUP;
            3'h3: seq_data = (f_op == `FAPES_OP_PROGRAM) ? f_data
                                                         : `FAPES_UNLOCK_DATA1;
            3'h4: seq_data = `FAPES_UNLOCK_DATA2;
            3'h5: seq_data = (f_op == `FAPES_OP_SECTOR_ERASE) ? `FAPES_SECTOR_CONFIRM
                                                              : `FAPES_CHIP_CONFIRM;
            default: seq_data = `FAPES_UNLOCK_DATA1;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Data pin synchroniser

always @(posedge clock or posedge rst) begin
    if (rst) begin
        dq_meta <= 8'h00;
        dq_sync <= 8'h00;
    end else begin
        dq_meta <= flash_dq_in;
        dq_sync <= dq_meta;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer

always @(posedge clock or posedge rst) begin
    if (rst) begin
        state        <= S_IDLE;
        op           <= `FAPES_OP_NONE;
        step         <= 3'h0;
        tgt_addr     <= 17'h00000;
        tgt_data     <= 8'h00;
        tgt_sector   <= 4'h0;
        wait_cnt     <= 10'h000;
        tmo_cnt      <= 28'h0000000;
        tmo_limit    <= 28'h0000000;
        cur_dq       <= 8'h00;
        prev_dq      <= 8'h00;
        have_prev    <= 1'b0;
        cmd_ready    <= 1'b0;
        op_done      <= 1'b0;
        op_fail      <= 1'b0;
        status_byte  <= 8'h00;
        flash_addr   <= 17'h00000;
        flash_dq_out <= 8'h00;
        flash_dq_oe  <= 1'b0;
        flash_ce_n   <= 1'b1;
        flash_oe_n   <= 1'b1;
        flash_we_n   <= 1'b1;
    end else begin
        op_done <= 1'b0;
        op_fail <= 1'b0;
        if (tmo_cnt != 28'hFFFFFFF) begin
            tmo_cnt <= tmo_cnt + 28'h0000001;
        end
        case (state)
            S_IDLE: begin
                cmd_ready <= 1'b1;
                if (cmd_ready && cmd_valid && cmd_op != `FAPES_OP_NONE) begin
                    cmd_ready  <= 1'b0;
                    op         <= cmd_op;
                    tgt_addr   <= cmd_addr;
                    tgt_data   <= cmd_data;
                    tgt_sector <= cmd_sector;
                    step       <= 3'h0;
                    have_prev  <= 1'b0;
                    case (cmd_op)
                        `FAPES_OP_PROGRAM:    tmo_limit <= PROG_CYCLES;
                        `FAPES_OP_CHIP_ERASE: tmo_limit <= CHIP_ERASE_CYCLES;
                        default:              tmo_limit <= SECTOR_ERASE_CYCLES;
                    endcase
                    state <= S_WSET;
                end
            end
            S_WSET: begin
                flash_addr   <= seq_addr(op, step, tgt_addr, sector_addr);
                flash_dq_out <= seq_data(op, step, tgt_data);
                flash_dq_oe  <= 1'b1;
                flash_ce_n   <= 1'b0;
                flash_oe_n   <= 1'b1;
                state        <= S_WLOW;
            end
            S_WLOW: begin
                flash_we_n <= 1'b0;
                state      <= S_WHIGH;
            end
            S_WHIGH: begin
                flash_we_n <= 1'b1;
                state      <= S_WEND;
            end
            S_WEND: begin
                flash_ce_n  <= 1'b1;
                flash_dq_oe <= 1'b0;
                if (step == last_step) begin
                    tmo_cnt  <= 28'h0000000;
                    wait_cnt <= 10'h000;
                    if (op == `FAPES_OP_SECTOR_ERASE) begin
                        state <= S_LOAD;
                    end else begin
                        state <= S_RSET;
                    end
                end else begin
                    step  <= step + 3'h1;
                    state <= S_WSET;
                end
            end
            S_LOAD: begin
                wait_cnt <= wait_cnt + 10'h001;
                if (wait_cnt == LOAD_CYCLES - 10'h001) begin
                    state <= S_RSET;
                end
            end
            S_RSET: begin
                flash_addr <= (op == `FAPES_OP_SECTOR_ERASE) ? sector_addr : tgt_addr;
                flash_ce_n <= 1'b0;
                flash_oe_n <= 1'b0;
                wait_cnt   <= 10'h000;
                state      <= S_RWAIT;
            end
            S_RWAIT: begin
                wait_cnt <= wait_cnt + 10'h001;
                if (wait_cnt == {7'h00, `FAPES_READ_WAIT}) begin
                    cur_dq     <= dq_sync;
                    flash_ce_n <= 1'b1;
                    flash_oe_n <= 1'b1;
                    state      <= S_CHECK;
                end
            end
            S_CHECK: begin
                prev_dq   <= cur_dq;
                have_prev <= 1'b1;
                if ((have_prev &&
                     prev_dq[`FAPES_TOGGLE_BIT] == cur_dq[`FAPES_TOGGLE_BIT]) ||
                    cur_dq[`FAPES_POLL_BIT] == expect7) begin
                    status_byte <= cur_dq;
                    op_done     <= 1'b1;
                    state       <= S_IDLE;
                end else if (tmo_cnt >= tmo_limit) begin
                    status_byte <= cur_dq;
                    op_fail     <= 1'b1;
                    state       <= S_IDLE;
                end else begin
                    state <= S_RSET;
                end
            end
            default: begin
                state <= S_IDLE;
            end
        endcase
    end
end

endmodule

// *** fapes_host_checker.sv ***
// Port assertions for the flash host sequencer
`timescale 1ns/100ps
module fapes_host_checker (
    input wire        clock,
    input wire        rst,
    input wire        cmd_valid,
    input wire [1:0]  cmd_op,
    input wire        cmd_ready,
    input wire        op_done,
    input wire        op_fail,
    input wire [16:0] flash_addr,
    input wire [7:0]  flash_dq_out,
    input wire        flash_dq_oe,
    input wire        flash_ce_n,
    input wire        flash_oe_n,
    input wire        flash_we_n
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    take_drop_a: assert property (cmd_ready && cmd_valid && cmd_op != 2'h0 |=> !cmd_ready)
        else $error("Command taken but ready stayed high");
    refuse_hold_a: assert property (cmd_ready && (!cmd_valid || cmd_op == 2'h0) |=> cmd_ready)
        else $error("Ready dropped without a command");
    done_ready_a: assert property (op_done |=> cmd_ready && !op_done)
        else $error("Done not a single pulse back to idle");
    fail_ready_a: assert property (op_fail |=> cmd_ready && !op_fail)
        else $error("Fail not a single pulse back to idle");
    idle_quiet_a: assert property (cmd_ready |-> flash_we_n && flash_oe_n && !flash_dq_oe)
        else $error("Flash access while idle");
    we_strobe_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
        else $error("Write strobe without select or data");
    we_pulse_a: assert property ($fell(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out)
        ##1 flash_we_n && $stable(flash_addr) && $stable(flash_dq_out))
        else $error("Write pulse length or hold wrong");
    read_hold_a: assert property ($fell(flash_oe_n) |->
        (!flash_oe_n && !flash_ce_n && !flash_dq_oe)[*5] ##1 flash_oe_n)
        else $error("Read strobe too short or bus fight");
endmodule

// *** fapes_flash_model.sv ***
// Behavioural flash device facing the host sequencer
`timescale 1ns/100ps
module fapes_flash_model #(
    parameter PROG_NS  = 20000,
    parameter ERASE_NS = 50000
) (
    input  wire [16:0] flash_addr,
    input  wire [7:0]  flash_dq_out,
    input  wire        flash_ce_n,
    input  wire        flash_oe_n,
    input  wire        flash_we_n,
    input  wire        stuck,
    output wire [7:0]  flash_dq_in
);
    reg  [7:0] mem [0:131071];
    reg  [7:0] q, prev;
    reg        poll, tog, er;
    integer    n_wr, i;
    realtime   busy_end, t_wr, t_rd;
    initial begin
        for (i = 0; i < 131072; i = i + 1) mem[i] = 8'hFF;
        {q, prev, poll, tog, er} = 19'h00000;
        n_wr = 0;
        busy_end = 0;
        t_wr = 0;
        t_rd = 0;
    end
    ////////////////////////////////////////
    always @(posedge flash_we_n) if (!flash_ce_n) begin
        n_wr = n_wr + 1;
        t_wr = $realtime;
        t_rd = 0;
        if (prev == 8'hA0) begin
            mem[flash_addr] = mem[flash_addr] & flash_dq_out;
            poll = ~flash_dq_out[7];
            busy_end = $realtime + PROG_NS;
            prev = 8'h00;
        end else begin
            if (er && flash_dq_out == 8'h10) begin
                for (i = 0; i < 131072; i = i + 1) mem[i] = 8'hFF;
                busy_end = $realtime + ERASE_NS;
            end
            if (er && flash_dq_out == 8'h30) begin
                for (i = 0; i < 8192; i = i + 1) mem[{flash_addr[16:13], i[12:0]}] = 8'hFF;
                busy_end = $realtime + 80000 + ERASE_NS;
            end
            if (er && (flash_dq_out == 8'h10 || flash_dq_out == 8'h30)) poll = 1'b0;
            er = (flash_dq_out == 8'h80) || (er && flash_dq_out != 8'h10 && flash_dq_out != 8'h30);
            prev = flash_dq_out;
        end
    end
    always @(negedge flash_oe_n) #1 if (!flash_ce_n) begin
        if (t_rd == 0) t_rd = $realtime;
        tog = ~tog;
        q = (stuck || $realtime < busy_end) ? {poll, tog, 6'h00} : mem[flash_addr];
    end
    assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? q : ~q;
endmodule

// *** fapes_host_test.sv ***
// Self-checking bench for the flash host sequencer
`timescale 1ns/100ps
module fapes_host_test;
    reg         clock, rst, cmd_valid, stuck, seen_fail;
    reg  [1:0]  cmd_op;
    reg  [16:0] cmd_addr;
    reg  [3:0]  cmd_sector;
    reg  [7:0]  cmd_data, stat;
    wire        cmd_ready, op_done, op_fail, dq_oe, ce_n, oe_n, we_n;
    wire [7:0]  status_byte, dq_out, dq_in;
    wire [16:0] f_addr;
    integer     err_total, n_tests, ncyc, w;
    fapes_host #(.SECTOR_ERASE_CYCLES(28'h00007D0), .CHIP_ERASE_CYCLES(28'h0000BB8)) dut_u (
        .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_sector(cmd_sector), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .op_done(op_done), .op_fail(op_fail),
        .status_byte(status_byte), .flash_addr(f_addr), .flash_dq_out(dq_out),
        .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n));
    fapes_flash_model model_u (.flash_addr(f_addr), .flash_dq_out(dq_out), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .stuck(stuck), .flash_dq_in(dq_in));
    ////////////////////////////////////////
    task summarize;
        $display("Comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task run_op(input [1:0] op, input [16:0] a, input [3:0] s, input [7:0] d);
        w = model_u.n_wr;
        @(posedge clock);
        {cmd_valid, cmd_op, cmd_addr, cmd_sector, cmd_data} <= {1'b1, op, a, s, d};
        ncyc = 0;
        @(negedge clock);
        while (cmd_ready !== 1'b0 && ncyc < 20) begin
            @(negedge clock);
            ncyc = ncyc + 1;
        end
        if (ncyc >= 20) begin
            err_total = err_total + 1;
            summarize();
        end
        @(posedge clock);
        cmd_valid <= 1'b0;
        ncyc = 0;
        while (op_done !== 1'b1 && op_fail !== 1'b1 && ncyc < 40000) begin
            @(negedge clock);
            ncyc = ncyc + 1;
        end
        if (ncyc < 40000) begin
            stat = status_byte;
            seen_fail = op_fail;
        end else begin
            err_total = err_total + 1;
            summarize();
        end
    endtask
    task t_refuse;
        @(posedge clock);
        {cmd_valid, cmd_op} <= 3'h4;
        repeat (4) @(posedge clock);
        cmd_valid <= 1'b0;
        @(negedge clock);
        chk(cmd_ready, 1);
        chk(model_u.n_wr, 0);
    endtask
    task t_program(input [16:0] a, input [7:0] d);
        run_op(2'h1, a, 4'h0, d);
        chk(seen_fail, 0);
        chk(stat, d);
        chk(model_u.n_wr - w, 4);
        chk(model_u.mem[a], d);
        chk(model_u.t_rd > model_u.t_wr, 1);
    endtask
    task t_sector;
        run_op(2'h3, 17'h00000, 4'h2, 8'h00);
        chk(seen_fail, 0);
        chk(stat, 8'hFF);
        chk(model_u.mem[17'h04010], 8'hFF);
        chk(model_u.mem[17'h0A5C3], 8'hC3);
        chk(model_u.t_rd - model_u.t_wr >= 80000, 1);
    endtask
    task t_chip;
        run_op(2'h2, 17'h00000, 4'h0, 8'h00);
        chk(seen_fail, 0);
        chk(stat, 8'hFF);
        chk(model_u.n_wr - w, 6);
        chk(model_u.mem[17'h0A5C3] & model_u.mem[17'h01234], 8'hFF);
    endtask
    task t_timeout;
        stuck <= 1'b1;
        run_op(2'h1, 17'h00100, 4'h0, 8'h00);
        chk(seen_fail, 1);
        chk(ncyc >= 2100, 1);
        chk(stat[7], 1);
        stuck <= 1'b0;
    endtask
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        {rst, cmd_valid, stuck, cmd_op, cmd_addr, cmd_sector, cmd_data} = 34'h200000000;
        err_total = 0;
        n_tests = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_refuse();
        t_program(17'h01234, 8'h5A);
        t_program(17'h0A5C3, 8'hC3);
        t_program(17'h04010, 8'h3C);
        t_sector();
        t_chip();
        t_timeout();
        summarize();
    end
endmodule
bind fapes_host fapes_host_checker chk_u (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_ready(cmd_ready), .op_done(op_done), .op_fail(op_fail),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
